/* File: src/cms_sequencer.sv */
`timescale 1ns/1ps
// What this block does
// - Plug-in with low battery restores register defaults
// - Bus limit field ignored until first host write
// - Detected adapter sets limit; unknown means SDP
// - SDP timer expiry locks standby until replug
// - SDP with good battery waits; write resumes
// - SDP with disable pin holds regulator off
// - CDP/DCP uses safety timer and 1500 mA
// - Limit pin picks bus limit without detection
// - Short battery: 50 mA linear, default system voltage
// - Pre-charge between short and minimum thresholds
// - Pre-charge and fast-charge entries raise flags; charging status bit
// - Fast charge above minimum until float voltage
// - Good-battery crossing raises flag and power-ok
// - Float voltage reached enters constant voltage
// - Termination after 30 ms low current
// - Terminate only in CV, no other loop
// - Recharge below float minus offset unless disabled
// - No termination: low-current flag, keep charging
// - Top-off starts 400 ms after termination
// - Top-off retries battery detection every 5 s
// - Top-off timer field ends top-off
// - System load takes priority over battery current
module cms_sequencer #(
  parameter bit DETECT_VARIANT = 1'b1,
  parameter bit LOW_VARIANT = 1'b0,
  parameter int MS_CYCLES = cms_pkg::MS_CYCLES_DEF
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire cms_pkg::cms_sense_t sense,
  input wire logic reg_wr_stb,
  input wire logic reg_rd_stb,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic host_ctrl,
  output logic [6:0] bus_limit_code,
  output logic safety_timer_en,
  output logic regulator_on,
  output logic [1:0] batt_switch_mode,
  output logic [5:0] charge_current_code,
  output logic [1:0] sys_voltage_code,
  output logic [7:0] float_voltage_code,
  output logic [2:0] good_thr_code,
  output logic [1:0] term_current_code,
  output logic charge_throttle,
  output logic stat_n,
  output logic bdet_retry
);
  import cms_pkg::*;

  // ********************
  // Input synchronisers
  // ********************
  cms_sense_t meta_reg, s;
  always_ff @(posedge sys_clk) begin
    meta_reg <= sense;
    s <= meta_reg;
  end

  // ********************
  // Millisecond enable
  // ********************
  logic [15:0] div_reg;
  logic ms_tick;
  always_ff @(posedge sys_clk) begin
    if (rst || div_reg == 16'(MS_CYCLES - 1)) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end
  assign ms_tick = (div_reg == 16'(MS_CYCLES - 1));

  // ********************
  // Configuration registers
  // ********************
  logic src_prev_reg, plug_evt, defaults;
  logic [7:0] thr_reg, sysv_reg, ctrl_reg, float_reg, fast_reg, pre_reg, bus_reg, to_reg;
  assign plug_evt = s.src_valid && !src_prev_reg;
  assign defaults = rst || (plug_evt && s.below_min);

  always_ff @(posedge sys_clk) begin
    if (defaults) begin
      thr_reg <= DEF_BATT_THR;
      sysv_reg <= DEF_SYS_V;
      ctrl_reg <= DEF_CHG_CTRL;
      float_reg <= DEF_FLOAT_V;
      fast_reg <= DEF_FAST_I;
      pre_reg <= DEF_PRE_TERM;
      bus_reg <= DEF_BUS_LIM;
      to_reg <= DEF_TOPOFF;
    end else if (reg_wr_stb) begin
      unique case (reg_addr)
        ADDR_BATT_THR: thr_reg <= reg_wdata;
        ADDR_SYS_V: sysv_reg <= reg_wdata;
        ADDR_CHG_CTRL: ctrl_reg <= reg_wdata;
        ADDR_FLOAT_V: float_reg <= reg_wdata;
        ADDR_FAST_I: fast_reg <= reg_wdata;
        ADDR_PRE_TERM: pre_reg <= reg_wdata;
        ADDR_BUS_LIM: bus_reg <= reg_wdata;
        ADDR_TOPOFF: to_reg <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ********************
  // Host control and auto-charge limits
  // ********************
  logic host_reg, is_sdp, sdp_auto;
  logic [6:0] sdp_lim, auto_lim;
  always_ff @(posedge sys_clk) begin
    if (rst || plug_evt) begin
      host_reg <= 1'b0;
    end else if (reg_wr_stb && s.src_valid) begin
      host_reg <= 1'b1;
    end
  end
  // Unidentified adapters fall back to the most conservative profile
  assign is_sdp = DETECT_VARIANT && s.adapter != ADAPT_CDP && s.adapter != ADAPT_DCP;
  // A plug-in clears host control only at the next edge, so treat that cycle as auto already
  assign sdp_auto = is_sdp && (plug_evt || !host_reg);
  assign sdp_lim = LOW_VARIANT ? LIM_100MA : LIM_500MA;
  always_comb begin
    if (DETECT_VARIANT) begin
      auto_lim = is_sdp ? sdp_lim : LIM_1500MA;
    end else begin
      auto_lim = s.current_limit_pin ? sdp_lim : LIM_1500MA;
    end
  end

  // ********************
  // Charge state machine
  // ********************
  cms_state_t state_reg, state_next, start_st;
  logic [MS_W-1:0] st_ms_reg, sdp_ms_reg, term_ms_reg, retry_ms_reg;
  logic hold_good_reg, charging, term_cond, term_done, sdp_exp, to_exp;
  logic [MS_W-1:0] to_len;

  assign charging = state_reg inside {ST_LINEAR, ST_PRE, ST_FAST, ST_CV};
  // Other regulation loops or supplemental mode mask termination
  assign term_cond = state_reg == ST_CV && ctrl_reg[TE_BIT] && s.ichg_below_term
                     && !s.loop_active && !s.suppl_active;
  assign term_done = term_cond && term_ms_reg > TERM_MS;
  assign sdp_exp = sdp_ms_reg >= (LOW_VARIANT ? SDP_LONG_MS : SDP_SHORT_MS);
  assign to_len = MS_W'({20'h0, to_reg[2:0]} + 23'h1) * TOPOFF_STEP_MS;
  assign to_exp = state_reg == ST_TOPOFF && st_ms_reg >= to_len;

  always_comb begin
    if (s.below_short) begin
      start_st = ST_LINEAR;
    end else if (s.below_min) begin
      start_st = ST_PRE;
    end else begin
      start_st = ST_FAST;
    end
  end

  always_comb begin
    state_next = state_reg;
    if (!s.src_valid) begin
      state_next = ST_WAIT;
    end else if (charging && sdp_auto && sdp_exp) begin
      state_next = ST_LOCK;
    end else begin
      unique case (state_reg)
        ST_WAIT: begin
          if (sdp_auto && (s.above_good || s.disable_pin)) begin
            state_next = ST_STANDBY;
          end else begin
            state_next = start_st;
          end
        end
        ST_LINEAR: if (!s.below_short) state_next = ST_PRE;
        ST_PRE: if (!s.below_min) state_next = ST_FAST;
        ST_FAST: if (s.at_float) state_next = ST_CV;
        ST_CV: begin
          if (term_done) begin
            state_next = ctrl_reg[TOPOFF_ENABLE_BIT] ? ST_TO_WAIT : ST_IDLE;
          end
        end
        ST_TO_WAIT: if (st_ms_reg >= DELAY_MS) state_next = ST_TOPOFF;
        ST_TOPOFF: if (to_exp) state_next = ST_IDLE;
        ST_IDLE: begin
          if (!ctrl_reg[RECHARGE_DISABLE_BIT] && s.below_recharge) begin
            state_next = start_st;
          end
        end
        ST_STANDBY: begin
          if (host_reg || (!hold_good_reg && !s.disable_pin)) begin
            state_next = start_st;
          end
        end
        ST_LOCK: state_next = ST_LOCK;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= ST_WAIT;
      src_prev_reg <= 1'b0;
      hold_good_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      src_prev_reg <= s.src_valid;
      if (state_reg == ST_WAIT) begin
        hold_good_reg <= sdp_auto && s.above_good;
      end
    end
  end

  // ********************
  // Timers
  // ********************
  always_ff @(posedge sys_clk) begin
    if (rst || state_next != state_reg) begin
      st_ms_reg <= '0;
    end else if (ms_tick) begin
      st_ms_reg <= st_ms_reg + 23'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || plug_evt || !sdp_auto) begin
      sdp_ms_reg <= '0;
    end else if (ms_tick && charging && !sdp_exp) begin
      sdp_ms_reg <= sdp_ms_reg + 23'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !term_cond) begin
      term_ms_reg <= '0;
    end else if (ms_tick && !term_done) begin
      term_ms_reg <= term_ms_reg + 23'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || state_reg != ST_TOPOFF || retry_ms_reg >= RETRY_MS) begin
      retry_ms_reg <= '0;
    end else if (ms_tick) begin
      retry_ms_reg <= retry_ms_reg + 23'h1;
    end
  end

  // ********************
  // Status and sticky flags
  // ********************
  logic good_prev_reg, lowi_prev_reg, cmp_reg;
  logic [7:0] fa_reg, fb_reg, fc_reg, fa_set, fb_set, fc_set;
  logic rd_a, rd_b, rd_c, low_evt;
  assign low_evt = !ctrl_reg[TE_BIT] && s.ichg_below_term && !lowi_prev_reg
                   && state_reg inside {ST_FAST, ST_CV};
  assign rd_a = reg_rd_stb && reg_addr == ADDR_FLAGS_A;
  assign rd_b = reg_rd_stb && reg_addr == ADDR_FLAGS_B;
  assign rd_c = reg_rd_stb && reg_addr == ADDR_FLAGS_C;

  always_comb begin
    fa_set = '0;
    fb_set = '0;
    fc_set = '0;
    fa_set[WEAK_BATTERY_INTERRUPT_BIT] = state_next == ST_PRE && state_reg != ST_PRE;
    fa_set[CHARGE_MODE_INTERRUPT_BIT] = state_next == ST_FAST && state_reg != ST_FAST;
    fa_set[CHARGE_END_INTERRUPT_BIT] = term_done;
    fa_set[GOODBAT_BIT] = s.above_good != good_prev_reg;
    fb_set[LOW_CURRENT_INTERRUPT_BIT] = low_evt;
    fc_set[TOPOFF_DONE_INTERRUPT_BIT] = to_exp;
  end

  // A set arriving with the read-clear survives the clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fa_reg <= '0;
      fb_reg <= '0;
      fc_reg <= '0;
      good_prev_reg <= 1'b0;
      lowi_prev_reg <= 1'b0;
    end else begin
      fa_reg <= (rd_a ? 8'h00 : fa_reg) | fa_set;
      fb_reg <= (rd_b ? 8'h00 : fb_reg) | fb_set;
      fc_reg <= (rd_c ? 8'h00 : fc_reg) | fc_set;
      good_prev_reg <= s.above_good;
      lowi_prev_reg <= s.ichg_below_term;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || plug_evt || (state_reg == ST_IDLE && state_next != ST_IDLE)) begin
      cmp_reg <= 1'b0;
    end else if (term_done || to_exp) begin
      cmp_reg <= 1'b1;
    end
  end

  logic [7:0] st_a, st_b, mon;
  always_comb begin
    st_a = '0;
    st_b = '0;
    mon = '0;
    st_a[PRE_BIT] = state_reg == ST_PRE;
    st_a[STAT_BIT] = charging;
    st_a[POWER_OK_STATUS_BIT] = s.above_good;
    st_b[LOWI_BIT] = !ctrl_reg[TE_BIT] && s.ichg_below_term && charging;
    st_b[6:5] = s.adapter;
    st_b[CMP_BIT] = cmp_reg;
    st_b[TOPOFF_STATUS_BIT] = state_reg == ST_TOPOFF;
    mon[CV_BIT] = state_reg == ST_CV;
    mon[TERM_CURRENT_MONITOR_BIT] = s.ichg_below_term && charging;
  end

  // ********************
  // Register read port
  // ********************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= '0;
    end else if (reg_rd_stb) begin
      unique case (reg_addr)
        ADDR_STATUS_A: reg_rdata <= st_a;
        ADDR_STATUS_B: reg_rdata <= st_b;
        ADDR_FLAGS_A: reg_rdata <= fa_reg;
        ADDR_FLAGS_B: reg_rdata <= fb_reg;
        ADDR_FLAGS_C: reg_rdata <= fc_reg;
        ADDR_BATT_THR: reg_rdata <= thr_reg;
        ADDR_SYS_V: reg_rdata <= sysv_reg;
        ADDR_CHG_CTRL: reg_rdata <= ctrl_reg;
        ADDR_FLOAT_V: reg_rdata <= float_reg;
        ADDR_FAST_I: reg_rdata <= fast_reg;
        ADDR_PRE_TERM: reg_rdata <= pre_reg;
        ADDR_BUS_LIM: reg_rdata <= bus_reg;
        ADDR_TOPOFF: reg_rdata <= to_reg;
        ADDR_MONITOR: reg_rdata <= mon;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ********************
  // Power-stage controls
  // ********************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      host_ctrl <= 1'b0;
      bus_limit_code <= LIM_500MA;
      safety_timer_en <= 1'b0;
      regulator_on <= 1'b0;
      batt_switch_mode <= SW_ON;
      charge_current_code <= '0;
      sys_voltage_code <= DEF_SYS_V[1:0];
      float_voltage_code <= DEF_FLOAT_V;
      good_thr_code <= DEF_BATT_THR[5:3];
      term_current_code <= DEF_PRE_TERM[7:6];
      charge_throttle <= 1'b0;
      stat_n <= 1'b1;
      bdet_retry <= 1'b0;
    end else begin
      host_ctrl <= host_reg;
      bus_limit_code <= host_reg ? bus_reg[6:0] : auto_lim;
      safety_timer_en <= charging && !sdp_auto;
      regulator_on <= !(state_reg inside {ST_WAIT, ST_STANDBY, ST_LOCK});
      unique case (state_reg)
        ST_LINEAR, ST_PRE: batt_switch_mode <= SW_LINEAR;
        ST_CV, ST_FAST, ST_TOPOFF: batt_switch_mode <= SW_ON;
        ST_TO_WAIT, ST_IDLE: batt_switch_mode <= SW_OFF;
        default: batt_switch_mode <= SW_ON;
      endcase
      if (state_reg == ST_LINEAR) begin
        charge_current_code <= SHORT_I_CODE;
      end else if (state_reg == ST_PRE) begin
        charge_current_code <= {2'b00, pre_reg[3:0]};
      end else begin
        charge_current_code <= fast_reg[5:0];
      end
      sys_voltage_code <= (state_reg == ST_LINEAR) ? DEF_SYS_V[1:0] : sysv_reg[1:0];
      float_voltage_code <= float_reg;
      good_thr_code <= thr_reg[5:3];
      term_current_code <= pre_reg[7:6];
      // Battery current yields so the system rail is fed first
      charge_throttle <= s.sys_limited && (charging || state_reg == ST_TOPOFF);
      stat_n <= !charging;
      bdet_retry <= retry_ms_reg >= RETRY_MS && !to_reg[TOPOFF_DETECT_DISABLE_BIT];
    end
  end

  // ********************
  // Checks
  // ********************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  weak_battery_interrupt_flag_a: assert property (state_reg != ST_PRE ##1 state_reg == ST_PRE |-> fa_reg[WEAK_BATTERY_INTERRUPT_BIT])
    else $error("weak battery flag missing");
  charge_mode_interrupt_flag_a: assert property (state_reg != ST_FAST ##1 state_reg == ST_FAST |-> fa_reg[CHARGE_MODE_INTERRUPT_BIT])
    else $error("charge mode flag missing");
  term_in_cv_a: assert property (fa_set[CHARGE_END_INTERRUPT_BIT] |-> state_reg == ST_CV && ctrl_reg[TE_BIT])
    else $error("termination outside CV");
  term_deglitch_a: assert property (term_done |-> $past(term_cond, 2))
    else $error("termination without deglitch");
  bus_limit_host_a: assert property (host_reg |=> bus_limit_code == $past(bus_reg[6:0]))
    else $error("bus limit not host value");
  cv_monitor_a: assert property (reg_rd_stb && reg_addr == ADDR_MONITOR |=> reg_rdata[CV_BIT] == $past(state_reg == ST_CV))
    else $error("CV monitor wrong");
  lock_hold_a: assert property (state_reg == ST_LOCK && s.src_valid |=> state_reg == ST_LOCK)
    else $error("lock left without replug");
  topoff_delay_a: assert property (state_reg == ST_TO_WAIT ##1 state_reg == ST_TOPOFF |-> $past(st_ms_reg) >= DELAY_MS)
    else $error("top-off began early");
  stat_pin_a: assert property (charging |=> !stat_n)
    else $error("stat pin high while charging");
  host_clear_a: assert property (plug_evt |=> !host_reg)
    else $error("host control kept over plug-in");
endmodule

/* File: src/cms_pkg.sv */
package cms_pkg;
  // ********************
  // Register offsets
  // ********************
  localparam logic [7:0] ADDR_STATUS_A = 8'h00;
  localparam logic [7:0] ADDR_STATUS_B = 8'h01;
  localparam logic [7:0] ADDR_FLAGS_A = 8'h04;
  localparam logic [7:0] ADDR_FLAGS_B = 8'h05;
  localparam logic [7:0] ADDR_FLAGS_C = 8'h06;
  localparam logic [7:0] ADDR_BATT_THR = 8'h0c;
  localparam logic [7:0] ADDR_SYS_V = 8'h0d;
  localparam logic [7:0] ADDR_CHG_CTRL = 8'h0e;
  localparam logic [7:0] ADDR_FLOAT_V = 8'h11;
  localparam logic [7:0] ADDR_FAST_I = 8'h12;
  localparam logic [7:0] ADDR_PRE_TERM = 8'h13;
  localparam logic [7:0] ADDR_BUS_LIM = 8'h14;
  localparam logic [7:0] ADDR_TOPOFF = 8'h1b;
  localparam logic [7:0] ADDR_MONITOR = 8'h20;
  // ********************
  // Reset values
  // ********************
  localparam logic [7:0] DEF_BATT_THR = 8'h00;
  localparam logic [7:0] DEF_SYS_V = 8'h00;
  localparam logic [7:0] DEF_CHG_CTRL = 8'h08;
  localparam logic [7:0] DEF_FLOAT_V = 8'h00;
  localparam logic [7:0] DEF_FAST_I = 8'h00;
  localparam logic [7:0] DEF_PRE_TERM = 8'h00;
  localparam logic [7:0] DEF_BUS_LIM = 8'h00;
  localparam logic [7:0] DEF_TOPOFF = 8'h00;
  // ********************
  // Field positions
  // ********************
  localparam int TE_BIT = 3;
  localparam int TOPOFF_ENABLE_BIT = 2;
  localparam int RECHARGE_DISABLE_BIT = 5;
  localparam int TOPOFF_DETECT_DISABLE_BIT = 3;
  localparam int PRE_BIT = 2;
  localparam int STAT_BIT = 3;
  localparam int POWER_OK_STATUS_BIT = 4;
  localparam int LOWI_BIT = 7;
  localparam int CMP_BIT = 4;
  localparam int TOPOFF_STATUS_BIT = 3;
  localparam int WEAK_BATTERY_INTERRUPT_BIT = 1;
  localparam int CHARGE_MODE_INTERRUPT_BIT = 2;
  localparam int CHARGE_END_INTERRUPT_BIT = 3;
  localparam int GOODBAT_BIT = 4;
  localparam int LOW_CURRENT_INTERRUPT_BIT = 7;
  localparam int TOPOFF_DONE_INTERRUPT_BIT = 7;
  localparam int CV_BIT = 0;
  localparam int TERM_CURRENT_MONITOR_BIT = 7;
  // ********************
  // Codes and timing
  // ********************
  localparam logic [1:0] ADAPT_CDP = 2'h1;
  localparam logic [1:0] ADAPT_DCP = 2'h2;
  localparam logic [6:0] LIM_100MA = 7'h01;
  localparam logic [6:0] LIM_500MA = 7'h05;
  localparam logic [6:0] LIM_1500MA = 7'h0f;
  localparam logic [5:0] SHORT_I_CODE = 6'h01;
  localparam logic [1:0] SW_OFF = 2'h0;
  localparam logic [1:0] SW_LINEAR = 2'h1;
  localparam logic [1:0] SW_ON = 2'h2;
  localparam int CLK_HZ = 25_000_000;
  localparam int MS_CYCLES_DEF = CLK_HZ / 1000;
  localparam int TERM_DEGLITCH_MS = 30;
  localparam int TOPOFF_DELAY_MS = 400;
  localparam int BDET_RETRY_S = 5;
  localparam int SDP_SHORT_MIN = 2;
  localparam int SDP_LONG_MIN = 45;
  localparam int TOPOFF_STEP_MIN = 10;
  localparam int MS_W = 23;
  localparam logic [MS_W-1:0] TERM_MS = MS_W'(TERM_DEGLITCH_MS);
  localparam logic [MS_W-1:0] DELAY_MS = MS_W'(TOPOFF_DELAY_MS);
  localparam logic [MS_W-1:0] RETRY_MS = MS_W'(BDET_RETRY_S * 1000);
  localparam logic [MS_W-1:0] SDP_SHORT_MS = MS_W'(SDP_SHORT_MIN * 60000);
  localparam logic [MS_W-1:0] SDP_LONG_MS = MS_W'(SDP_LONG_MIN * 60000);
  localparam logic [MS_W-1:0] TOPOFF_STEP_MS = MS_W'(TOPOFF_STEP_MIN * 60000);
  // ********************
  // Types
  // ********************
  typedef struct packed {
    logic src_valid;
    logic below_short;
    logic below_min;
    logic above_good;
    logic at_float;
    logic below_recharge;
    logic ichg_below_term;
    logic loop_active;
    logic suppl_active;
    logic sys_limited;
    logic disable_pin;
    logic current_limit_pin;
    logic [1:0] adapter;
  } cms_sense_t;
  typedef enum logic [9:0] {
    ST_WAIT = 10'h001,
    ST_LINEAR = 10'h002,
    ST_PRE = 10'h004,
    ST_FAST = 10'h008,
    ST_CV = 10'h010,
    ST_TO_WAIT = 10'h020,
    ST_TOPOFF = 10'h040,
    ST_IDLE = 10'h080,
    ST_STANDBY = 10'h100,
    ST_LOCK = 10'h200
  } cms_state_t;
endpackage

/* File: sim/cms_batt_model.sv */
`timescale 1ns/1ps
// ********************
// Battery and adapter stand-in
// ********************
module cms_batt_model (
  input wire logic plugged,
  input wire logic [2:0] vbat_lvl,
  input wire logic [1:0] adapter,
  input wire logic ichg_low,
  input wire logic [3:0] pins,
  output cms_pkg::cms_sense_t sense
);
  import cms_pkg::*;
  // Levels: 0 short, 1 weak, 2 above min, 3 above good, 4 at float, 5 sagged below recharge
  always_comb begin
    sense = '0;
    sense.src_valid = plugged;
    sense.below_short = (vbat_lvl == 3'h0);
    sense.below_min = (vbat_lvl < 3'h2);
    sense.above_good = (vbat_lvl >= 3'h3);
    sense.at_float = (vbat_lvl == 3'h4);
    sense.below_recharge = (vbat_lvl != 3'h4);
    // Current only tapers once the cell sits at float voltage
    sense.ichg_below_term = ichg_low && (vbat_lvl == 3'h4);
    sense.disable_pin = pins[0];
    sense.current_limit_pin = pins[1];
    sense.loop_active = pins[2];
    sense.sys_limited = pins[3];
    sense.adapter = adapter;
  end
endmodule

/* File: sim/cms_sequencer_bench.sv */
`timescale 1ns/1ps
module cms_sequencer_bench;
  import cms_pkg::*;
  logic sys_clk, rst, plugged, ichg_low, wr, rd, host_ctrl, safety_timer_en, regulator_on;
  logic charge_throttle, stat_n, bdet_retry;
  logic [2:0] lvl, good_thr_code;
  logic [1:0] adapter, batt_switch_mode, sys_voltage_code, term_current_code;
  logic [3:0] pins;
  logic [5:0] charge_current_code;
  logic [6:0] bus_limit_code;
  logic [7:0] addr, wdata, rdata, data, got, float_voltage_code;
  cms_sense_t sense;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  integer seed;
  bit seen;

  cms_batt_model batt (.plugged(plugged), .vbat_lvl(lvl), .adapter(adapter), .ichg_low(ichg_low),
    .pins(pins), .sense(sense));
  cms_sequencer #(.MS_CYCLES(4)) DUT (.sys_clk(sys_clk), .rst(rst), .sense(sense), .reg_wr_stb(wr),
    .reg_rd_stb(rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .host_ctrl(host_ctrl),
    .bus_limit_code(bus_limit_code), .safety_timer_en(safety_timer_en), .regulator_on(regulator_on),
    .batt_switch_mode(batt_switch_mode), .charge_current_code(charge_current_code),
    .sys_voltage_code(sys_voltage_code), .float_voltage_code(float_voltage_code),
    .good_thr_code(good_thr_code), .term_current_code(term_current_code),
    .charge_throttle(charge_throttle), .stat_n(stat_n), .bdet_retry(bdet_retry));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // ********************
  // Helpers
  // ********************
  function automatic logic [7:0] exp_limit(input logic [1:0] ad);
    return (ad == ADAPT_CDP || ad == ADAPT_DCP) ? {1'b0, LIM_1500MA} : {1'b0, LIM_500MA};
  endfunction

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen_v);
    checks_done++;
    if (seen_v !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen_v);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge sys_clk);
    rd <= 1'b0;
    settle(1);
    d = rdata;
  endtask

  task automatic drive(input logic [2:0] v, input logic il, input logic [3:0] p, input int n);
    @(posedge sys_clk);
    lvl <= v;
    ichg_low <= il;
    pins <= p;
    settle(n);
  endtask

  // Unplug long enough for the synchronisers to see the gap
  task automatic plug(input logic [2:0] v, input logic [1:0] ad);
    @(posedge sys_clk);
    plugged <= 1'b0;
    settle(6);
    @(posedge sys_clk);
    lvl <= v;
    adapter <= ad;
    plugged <= 1'b1;
    settle(8);
  endtask

  task automatic test_done();
    $display("Counts: %0d checks, %0d miscompares", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      miscompares++;
      test_done();
    end
  end

  // ********************
  // Main sequence
  // ********************
  initial begin
    seed = 32'h28f4710f;
    {plugged, ichg_low, wr, rd, lvl, adapter, pins, addr, wdata} = '0;
    rst = 1'b1;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    settle(3);
    rd_reg(ADDR_CHG_CTRL, got);
    chk("chg_ctrl", DEF_CHG_CTRL, got);
    rd_reg(8'h3f, got);
    chk("unmapped", 8'h00, got);
    $display("reset test ended");
    for (int i = 0; i < 4; i++) begin
      plug(3'h2, 2'(i));
      chk("auto_limit", exp_limit(2'(i)), {1'b0, bus_limit_code});
      chk("safety_en", 8'(i == 1 || i == 2), 8'(safety_timer_en));
      chk("sw_mode", 8'(SW_ON), 8'(batt_switch_mode));
      rd_reg(ADDR_FLAGS_A, got);
      chk("charge_mode_interrupt", 8'h01, 8'(got[CHARGE_MODE_INTERRUPT_BIT]));
    end
    $display("adapter test ended");
    data = 8'($random(seed)) & 8'h7f;
    wr_reg(ADDR_BUS_LIM, data);
    settle(2);
    chk("host_ctrl", 8'h01, 8'(host_ctrl));
    chk("host_limit", data, {1'b0, bus_limit_code});
    plug(3'h2, ADAPT_DCP);
    chk("host_clear", 8'h00, 8'(host_ctrl));
    rd_reg(ADDR_BUS_LIM, got);
    chk("kept", data, got);
    plug(3'h0, ADAPT_DCP);
    chk("linear", 8'(SW_LINEAR), 8'(batt_switch_mode));
    chk("short_i", 8'(SHORT_I_CODE), 8'(charge_current_code));
    chk("sys_v", 8'(DEF_SYS_V[1:0]), 8'(sys_voltage_code));
    rd_reg(ADDR_BUS_LIM, got);
    chk("defaults", DEF_BUS_LIM, got);
    $display("host control test ended");
    data = 8'($random(seed));
    wr_reg(ADDR_PRE_TERM, data);
    drive(3'h1, 1'b0, 4'h0, 8);
    chk("pre_i", {4'h0, data[3:0]}, 8'(charge_current_code));
    chk("term_i", {6'h0, data[7:6]}, 8'(term_current_code));
    rd_reg(ADDR_FLAGS_A, got);
    chk("weak_battery_interrupt", 8'h01, 8'(got[WEAK_BATTERY_INTERRUPT_BIT]));
    rd_reg(ADDR_STATUS_A, got);
    chk("pre_stat", 8'h03, {6'h0, got[PRE_BIT], got[STAT_BIT]});
    drive(3'h4, 1'b1, 4'hc, 200);
    chk("throttle", 8'h01, 8'(charge_throttle));
    chk("held_off", 8'h00, 8'(stat_n));
    rd_reg(ADDR_MONITOR, got);
    chk("cv_bit", 8'h01, 8'(got[CV_BIT]));
    drive(3'h4, 1'b1, 4'h0, 200);
    chk("term_stat", 8'h01, 8'(stat_n));
    chk("term_sw", 8'(SW_OFF), 8'(batt_switch_mode));
    rd_reg(ADDR_STATUS_B, got);
    chk("cmp", 8'h01, 8'(got[CMP_BIT]));
    drive(3'h5, 1'b0, 4'h0, 8);
    chk("recharge", 8'h00, 8'(stat_n));
    $display("charge cycle test ended");
    wr_reg(ADDR_CHG_CTRL, 8'h0c);
    // Clear the charge-end flag left by the first termination
    rd_reg(ADDR_FLAGS_A, got);
    drive(3'h4, 1'b1, 4'h0, 200);
    rd_reg(ADDR_FLAGS_A, got);
    chk("charge_end_interrupt", 8'h01, 8'(got[CHARGE_END_INTERRUPT_BIT]));
    rd_reg(ADDR_STATUS_B, got);
    chk("to_early", 8'h00, 8'(got[TOPOFF_STATUS_BIT]));
    settle(1700);
    rd_reg(ADDR_STATUS_B, got);
    chk("to_late", 8'h01, 8'(got[TOPOFF_STATUS_BIT]));
    chk("to_stat", 8'h01, 8'(stat_n));
    seen = 1'b0;
    for (int n = 0; n < 21000 && !seen; n++) begin
      settle(1);
      seen = bdet_retry;
    end
    chk("retry", 8'h01, 8'(seen));
    $display("top-off test ended");
    plug(3'h2, ADAPT_DCP);
    wr_reg(ADDR_CHG_CTRL, 8'h00);
    drive(3'h4, 1'b1, 4'h0, 200);
    chk("no_term", 8'h00, 8'(stat_n));
    rd_reg(ADDR_FLAGS_B, got);
    chk("low_current_interrupt", 8'h01, 8'(got[LOW_CURRENT_INTERRUPT_BIT]));
    rd_reg(ADDR_STATUS_B, got);
    chk("lo_stat", 8'h02, {6'h0, got[LOWI_BIT], got[CMP_BIT]});
    plug(3'h3, 2'h0);
    chk("sdp_off", 8'h00, 8'(regulator_on));
    data = 8'($random(seed));
    wr_reg(ADDR_FLOAT_V, data);
    settle(4);
    chk("sdp_on", 8'h01, 8'(regulator_on));
    chk("float", data, float_voltage_code);
    drive(3'h2, 1'b0, 4'h1, 2);
    plug(3'h2, 2'h3);
    chk("dis_off", 8'h00, 8'(regulator_on));
    rd_reg(ADDR_FLAGS_A, got);
    drive(3'h3, 1'b0, 4'h0, 8);
    chk("dis_on", 8'h01, 8'(regulator_on));
    rd_reg(ADDR_FLAGS_A, got);
    chk("good_int", 8'h01, 8'(got[GOODBAT_BIT]));
    rd_reg(ADDR_STATUS_A, got);
    chk("power_ok_status", 8'h01, 8'(got[POWER_OK_STATUS_BIT]));
    data = 8'($random(seed));
    wr_reg(ADDR_BATT_THR, data);
    settle(2);
    chk("good_thr", {5'h0, data[5:3]}, 8'(good_thr_code));
    $display("source test ended");
    test_done();
  end
endmodule
